// ### hw/tsdr_defs.vh
// Constants for the tile status and debug register bank.
// Included by tsdr_regs.v; definitions only.
`ifndef TSDR_DEFS_VH
`define TSDR_DEFS_VH
`define TSDR_ADDR_TILE_CELL_OSC    8'h07
`define TSDR_ADDR_TILE_WIRE_OSC    8'h08
`define TSDR_ADDR_PERIPH_CELL_OSC  8'h09
`define TSDR_ADDR_PERIPH_WIRE_OSC  8'h0A
`define TSDR_ADDR_MEMORY_SIZE      8'h0C
`define TSDR_ADDR_STATUS_WORD      8'h10
`define TSDR_ADDR_PROGRAM_COUNTER  8'h11
`define TSDR_ADDR_STACK_POINTER    8'h12
`define TSDR_ADDR_THREAD_SELECT    8'h13
`define TSDR_ADDR_REGISTER_SELECT  8'h14
`define TSDR_ADDR_ENTRY_CAUSE      8'h15
`define TSDR_STATUS_WORD_MASK      32'h000007DF
`define TSDR_STATUS_WRITE_MASK     32'h000006DF
`define TSDR_STATUS_RO_ISSUE_BIT   8
`define TSDR_CAUSE_NONE            3'h0
`define TSDR_CAUSE_HOST            3'h1
`define TSDR_CAUSE_DEBUG_CALL      3'h2
`define TSDR_CAUSE_INSTR_BREAK     3'h3
`define TSDR_CAUSE_DATA_WATCH      3'h4
`define TSDR_CAUSE_RESOURCE_WATCH  3'h5
`define TSDR_CAUSE_LSB             0
`define TSDR_THREAD_LSB            8
`define TSDR_INDEX_LSB             16
`define TSDR_OSC_WIDTH             16
`define TSDR_MEMORY_SIZE_DEFAULT   30'h00020000
`endif

// ### hw/tsdr_regs.v
// Tile status and debug register bank: oscillator counters, memory size,
// and the state captured on debug interrupt entry.
// Assumes the core presents reads and writes on CLK; oscillator edges arrive
// asynchronously and are synchronised here before counting.
// MEMORY_SIZE_WORDS must match the RAM fitted beside the core.
//
// Behaviour
// - Oscillator registers: 16-bit count, upper zero
// - Oscillator counts survive system reset
// - Four counters at addresses 0x07 to 0x0A
// - Memory size in bits 31:2, low zero
// - Debug entry captures status, PC, SP
// - Status word bit layout as defined
// - Thread 8-bit, register 5-bit operand selects
// - Cause code records trigger, resets zero
// - Breakpoint index zero for host, call
// - Lowest simultaneous breakpoint index wins
// - Thread number zero for host requests
`timescale 1ns/1ps
`default_nettype none
`include "tsdr_defs.vh"

module tsdr_regs #(
   parameter [29:0] MEMORY_SIZE_WORDS = `TSDR_MEMORY_SIZE_DEFAULT
) (
   // Clock and reset
   input  wire        CLK,
   input  wire        NRST,
   // Register access from the core
   input  wire [7:0]  ADDR,
   input  wire        WR_EN,
   input  wire [31:0] WR_DATA,
   input  wire        RD_EN,
   output reg  [31:0] RD_DATA,
   output reg         RD_VALID,
   // Debug mode and entry event from the pipeline
   input  wire        DEBUG_MODE,
   input  wire        DEBUG_ENTRY,
   input  wire [2:0]  ENTRY_CAUSE,
   input  wire [7:0]  ENTRY_THREAD,
   input  wire [3:0]  ENTRY_HIT,
   input  wire [31:0] SAVED_STATUS_WORD,
   input  wire [31:0] SAVED_PROGRAM_COUNTER,
   input  wire [31:0] SAVED_STACK_POINTER,
   // Ring oscillators: enables and asynchronous oscillator edges
   input  wire        CORE_OSC_ENABLE,
   input  wire        PERIPH_OSC_ENABLE,
   input  wire [3:0]  OSC_IN,
   // Operand selects for the remote register read
   output reg  [7:0]  REMOTE_THREAD,
   output reg  [4:0]  REMOTE_REGISTER
);

   // Lowest set hit bit; bit 0 has the highest priority
   function [1:0] tsdr_lowest;
      input [3:0] hit;
      begin
         if (hit[0]) begin
            tsdr_lowest = 2'h0;
         end else if (hit[1]) begin
            tsdr_lowest = 2'h1;
         end else if (hit[2]) begin
            tsdr_lowest = 2'h2;
         end else begin
            tsdr_lowest = 2'h3;
         end
      end
   endfunction

   // Oscillator registers show the count in the low half only
   function [31:0] tsdr_osc_word;
      input [15:0] count;
      begin
         tsdr_osc_word = {16'h0000, count};
      end
   endfunction

   // Packs cause, thread and index into their register fields
   function [31:0] tsdr_cause_word;
      input [2:0] code;
      input [7:0] thread;
      input [1:0] index;
      begin
         tsdr_cause_word = {14'h0000, index, thread, 5'h00, code};
      end
   endfunction

   // Host requests and debug calls name no hardware unit
   function [1:0] tsdr_entry_index;
      input [2:0] code;
      input [3:0] hit;
      begin
         if (code == `TSDR_CAUSE_HOST || code == `TSDR_CAUSE_DEBUG_CALL
             || hit == 4'h0) begin
            tsdr_entry_index = 2'h0;
         end else begin
            tsdr_entry_index = tsdr_lowest(hit);
         end
      end
   endfunction

   // Synchroniser, edge detector and counters
   reg  [3:0]  osc_meta;
   reg  [3:0]  osc_sync;
   reg  [3:0]  osc_prev;
   reg  [15:0] osc_count [0:3];
   wire [3:0]  osc_enable;
   reg  [31:0] status_word;
   reg  [31:0] program_counter;
   reg  [31:0] stack_pointer;
   reg  [2:0]  cause;
   reg  [7:0]  cause_thread;
   reg  [1:0]  cause_index;
   reg  [7:0]  next_cause_thread;
   reg  [1:0]  next_cause_index;
   reg  [31:0] next_rd_data;
   reg         debug_write;
   integer     i;

   // Counters power up at zero and carry no reset, so a system reset
   // leaves the last count readable
   initial begin
      for (i = 0; i < 4; i = i + 1) begin
         osc_count[i] = 16'h0000;
      end
   end

   // Tile oscillators follow the core enable, peripheral ones the other
   assign osc_enable = {PERIPH_OSC_ENABLE, PERIPH_OSC_ENABLE,
                        CORE_OSC_ENABLE, CORE_OSC_ENABLE};

   // Two flops settle the asynchronous edges; only the second feeds logic
   always @(posedge CLK) begin
      osc_meta <= OSC_IN;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
   end

   // No reset branch so a system reset leaves the counts intact
   always @(posedge CLK) begin
      for (i = 0; i < 4; i = i + 1) begin
         if (osc_enable[i] && osc_sync[i] && !osc_prev[i]) begin
            osc_count[i] <= osc_count[i] + 16'h0001;
         end
      end
   end

   // Outside debug mode every write vanishes without an answer
   always @* begin
      debug_write = WR_EN && DEBUG_MODE;
   end

   // Values that an entry in this cycle would capture
   always @* begin
      next_cause_thread = ENTRY_THREAD;
      next_cause_index  = tsdr_entry_index(ENTRY_CAUSE, ENTRY_HIT);
      if (ENTRY_CAUSE == `TSDR_CAUSE_HOST) begin
         next_cause_thread = 8'h00;
      end
   end

   // Saved status word, program counter and stack pointer
   // Entry wins over a write in the same cycle; that write is lost
   always @(posedge CLK) begin
      if (!NRST) begin
         status_word     <= 32'h00000000;
         program_counter <= 32'h00000000;
         stack_pointer   <= 32'h00000000;
      end else if (DEBUG_ENTRY) begin
         status_word     <= SAVED_STATUS_WORD & `TSDR_STATUS_WORD_MASK;
         program_counter <= SAVED_PROGRAM_COUNTER;
         stack_pointer   <= SAVED_STACK_POINTER;
      end else if (debug_write) begin
         case (ADDR)
            `TSDR_ADDR_STATUS_WORD: begin
               // Bit 8 stays read-only; only the masked fields take the write
               status_word <= (status_word & ~`TSDR_STATUS_WRITE_MASK)
                              | (WR_DATA & `TSDR_STATUS_WRITE_MASK);
            end
            `TSDR_ADDR_PROGRAM_COUNTER: begin
               program_counter <= WR_DATA;
            end
            `TSDR_ADDR_STACK_POINTER: begin
               stack_pointer <= WR_DATA;
            end
            default: begin
            end
         endcase
      end
   end

   // Cause, thread and index of the latest debug entry
   always @(posedge CLK) begin
      if (!NRST) begin
         cause        <= `TSDR_CAUSE_NONE;
         cause_thread <= 8'h00;
         cause_index  <= 2'h0;
      end else if (DEBUG_ENTRY) begin
         cause        <= ENTRY_CAUSE;
         cause_thread <= next_cause_thread;
         cause_index  <= next_cause_index;
      end else if (debug_write && ADDR == `TSDR_ADDR_ENTRY_CAUSE) begin
         cause        <= WR_DATA[2:0];
         cause_thread <= WR_DATA[15:8];
         cause_index  <= WR_DATA[17:16];
      end
   end

   // Operand selects for the remote register read
   always @(posedge CLK) begin
      if (!NRST) begin
         REMOTE_THREAD   <= 8'h00;
         REMOTE_REGISTER <= 5'h00;
      end else if (debug_write && !DEBUG_ENTRY) begin
         case (ADDR)
            `TSDR_ADDR_THREAD_SELECT: begin
               REMOTE_THREAD <= WR_DATA[7:0];
            end
            `TSDR_ADDR_REGISTER_SELECT: begin
               REMOTE_REGISTER <= WR_DATA[4:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Unmapped registers read back as zero
   always @* begin
      next_rd_data = 32'h00000000;
      case (ADDR)
         `TSDR_ADDR_TILE_CELL_OSC: begin
            next_rd_data = tsdr_osc_word(osc_count[0]);
         end
         `TSDR_ADDR_TILE_WIRE_OSC: begin
            next_rd_data = tsdr_osc_word(osc_count[1]);
         end
         `TSDR_ADDR_PERIPH_CELL_OSC: begin
            next_rd_data = tsdr_osc_word(osc_count[2]);
         end
         `TSDR_ADDR_PERIPH_WIRE_OSC: begin
            next_rd_data = tsdr_osc_word(osc_count[3]);
         end
         `TSDR_ADDR_MEMORY_SIZE: begin
            // Size is fixed per die, so it comes from a parameter
            next_rd_data = {MEMORY_SIZE_WORDS, 2'b00};
         end
         `TSDR_ADDR_STATUS_WORD: begin
            next_rd_data = status_word;
         end
         `TSDR_ADDR_PROGRAM_COUNTER: begin
            next_rd_data = program_counter;
         end
         `TSDR_ADDR_STACK_POINTER: begin
            next_rd_data = stack_pointer;
         end
         `TSDR_ADDR_THREAD_SELECT: begin
            next_rd_data = {24'h000000, REMOTE_THREAD};
         end
         `TSDR_ADDR_REGISTER_SELECT: begin
            next_rd_data = {27'h0000000, REMOTE_REGISTER};
         end
         `TSDR_ADDR_ENTRY_CAUSE: begin
            next_rd_data = tsdr_cause_word(cause, cause_thread, cause_index);
         end
         default: begin
            next_rd_data = 32'h00000000;
         end
      endcase
   end

   // Read data is registered; counts may be mid-change unless the
   // oscillator was stopped beforehand
   always @(posedge CLK) begin
      if (!NRST) begin
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= RD_EN;
      end
   end

   // RD_DATA holds the last answer between reads
   always @(posedge CLK) begin
      if (!NRST) begin
         RD_DATA <= 32'h00000000;
      end else if (RD_EN) begin
         RD_DATA <= next_rd_data;
      end
   end

endmodule
`default_nettype wire

// ### verification/tsdr_osc_model.sv
// Model of the four ring oscillators beside the core.
// Free running, unrelated in phase to CLK; the bank gates counting.
`timescale 1ns/1ps
`default_nettype none
module tsdr_osc_model (
   // Oscillator edges
   output var logic [3:0] osc
);
   // Slow enough that the two-flop synchroniser sees every level
   initial begin
      osc = 4'h5;
      forever #13.7 osc = ~osc;
   end
endmodule
`default_nettype wire

// ### verification/tsdr_regs_sva.sv
// Checker for tsdr_regs reads, debug capture and write gating.
// Bound to tsdr_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tsdr_regs_sva (
   // Bus
   input wire logic        CLK,
   input wire logic        NRST,
   input wire logic [7:0]  ADDR,
   input wire logic        WR_EN,
   input wire logic [31:0] WR_DATA,
   input wire logic        RD_EN,
   input wire logic [31:0] RD_DATA,
   input wire logic        RD_VALID,
   // Debug side
   input wire logic        DEBUG_MODE,
   input wire logic        DEBUG_ENTRY,
   input wire logic [2:0]  ENTRY_CAUSE,
   input wire logic [3:0]  ENTRY_HIT,
   input wire logic [7:0]  REMOTE_THREAD
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   logic [7:0] ra;
   // Address of the read now being answered
   always_ff @(posedge CLK) if (RD_EN) ra <= ADDR;
   function automatic logic [1:0] lo(input logic [3:0] h);
      return h[0] ? 2'h0 : h[1] ? 2'h1 : h[2] ? 2'h2 : h[3] ? 2'h3 : 2'h0;
   endfunction
   sequence s_entry_read;
      DEBUG_ENTRY ##1 RD_EN && ADDR == 8'h15 && !DEBUG_ENTRY && !WR_EN;
   endsequence
   a_osc_upper_zero: assert property (RD_VALID && ra inside {[8'h07:8'h0A]}
      |-> RD_DATA[31:16] == 16'h0) else $error("osc high bits set");
   a_size_low_zero: assert property (RD_VALID && ra == 8'h0C
      |-> RD_DATA[1:0] == 2'h0) else $error("size low bits set");
   a_status_reserved: assert property (RD_VALID && ra == 8'h10
      |-> RD_DATA[31:11] == 21'h0 && !RD_DATA[5]) else $error("status reserved set");
   a_cause_capture: assert property (s_entry_read
      |=> RD_DATA[2:0] == $past(ENTRY_CAUSE, 2)) else $error("cause mismatch");
   a_index_lowest: assert property (s_entry_read |=> RD_DATA[17:16] ==
      ($past(ENTRY_CAUSE, 2) < 3'h3 ? 2'h0 : lo($past(ENTRY_HIT, 2)))) else $error("bad index");
   a_host_thread: assert property (s_entry_read ##1 $past(ENTRY_CAUSE, 2) == 3'h1
      |-> RD_DATA[15:8] == 8'h0) else $error("host thread nonzero");
   a_write_ignored: assert property (WR_EN && !DEBUG_MODE && ADDR == 8'h13
      |=> $stable(REMOTE_THREAD)) else $error("write outside debug taken");
   a_write_taken: assert property (WR_EN && DEBUG_MODE && ADDR == 8'h13 && !DEBUG_ENTRY
      |=> {24'h0, REMOTE_THREAD} == ($past(WR_DATA) & 32'hFF)) else $error("select lost");
endmodule
bind tsdr_regs tsdr_regs_sva u_sva (.*);
`default_nettype wire

// ### verification/tsdr_regs_tb_top.sv
// Testbench for tsdr_regs: register reads, debug entries, gated writes.
// Drives at the falling edge; the oscillator model drives OSC_IN.
`timescale 1ns/1ps
`default_nettype none
module tsdr_regs_tb_top;
   logic        CLK = 0, NRST = 0, WR_EN = 0, RD_EN = 0, RD_VALID, DEBUG_MODE = 0;
   logic        DEBUG_ENTRY = 0, CORE_OSC_ENABLE = 0, PERIPH_OSC_ENABLE = 0;
   logic [7:0]  ADDR = 0, ENTRY_THREAD = 0, REMOTE_THREAD;
   logic [2:0]  ENTRY_CAUSE = 0;
   logic [3:0]  ENTRY_HIT = 0;
   logic [4:0]  REMOTE_REGISTER;
   logic [31:0] WR_DATA = 0, SAVED_STATUS_WORD = 0, SAVED_PROGRAM_COUNTER = 0;
   logic [31:0] SAVED_STACK_POINTER = 0, RD_DATA, rs = 32'hE3A4D1E8;
   wire logic [3:0] OSC_IN;
   logic [63:0] q[$];
   int          mismatches = 0, checks = 0, k;
   logic [15:0] cnt;
   tsdr_regs dut (.*);
   tsdr_osc_model osc_model (.osc(OSC_IN));
   initial begin
      forever #2 CLK = ~CLK;
   end
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic logic [1:0] lo(input logic [3:0] h);
      return h[0] ? 2'h0 : h[1] ? 2'h1 : h[2] ? 2'h2 : h[3] ? 2'h3 : 2'h0;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Entry pulse is dropped here so a read can follow it directly
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(negedge CLK);
      DEBUG_ENTRY = 1'b0;
      ADDR = a;
      RD_EN = 1'b1;
      q.push_back({m, e});
      @(negedge CLK);
      RD_EN = 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge CLK);
      ADDR = a;
      WR_DATA = d;
      WR_EN = 1'b1;
      @(negedge CLK);
      WR_EN = 1'b0;
   endtask
   task automatic enter(input logic [2:0] c);
      logic [31:0] r;
      r = rnd();
      @(negedge CLK);
      {ENTRY_CAUSE, ENTRY_THREAD, ENTRY_HIT} = {c, r[7:0], r[11:8]};
      SAVED_STATUS_WORD = rnd();
      SAVED_PROGRAM_COUNTER = rnd();
      SAVED_STACK_POINTER = r;
      DEBUG_ENTRY = 1'b1;
      rd(8'h15, '1, {14'h0, c < 3'h3 ? 2'h0 : lo(r[11:8]), c == 3'h1 ? 8'h0 : r[7:0], 5'h0, c});
      rd(8'h10, '1, SAVED_STATUS_WORD & 32'h7DF);
      rd(8'h11, '1, SAVED_PROGRAM_COUNTER);
      rd(8'h12, '1, r);
   endtask
   task automatic close_out();
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(negedge CLK) begin
      if (RD_VALID === 1'b1) begin
         if (q.size() == 0) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, RD_DATA, 32'h0);
         end else begin
            chk(RD_DATA & q[0][63:32], q[0][31:0]);
            void'(q.pop_front());
         end
      end
   end
   initial begin
      #20000;
      mismatches++;
      close_out();
   end
   initial begin
      repeat (3) @(negedge CLK);
      NRST = 1'b1;
      rd(8'h15, '1, 32'h0);
      rd(8'h0C, '1, 32'h00080000);
      {CORE_OSC_ENABLE, PERIPH_OSC_ENABLE} = 2'b11;
      repeat (300) @(negedge CLK);
      {CORE_OSC_ENABLE, PERIPH_OSC_ENABLE} = 2'b00;
      repeat (10) @(negedge CLK);
      for (k = 7; k < 11; k++) rd(k[7:0], 32'hFFFF0000, 32'h0);
      rd(8'h07, 32'h0, 32'h0);
      @(negedge CLK);
      cnt = RD_DATA[15:0];
      chk(32'(cnt > 16'd30 && cnt < 16'd60), 32'h1);
      NRST = 1'b0;
      repeat (3) @(negedge CLK);
      NRST = 1'b1;
      rd(8'h07, '1, {16'h0, cnt});
      rd(8'h15, '1, 32'h0);
      for (k = 0; k < 20; k++) enter(3'h1 + 3'(k % 5));
      wr(8'h13, 32'hFFFFFFA5);
      rd(8'h13, '1, 32'h0);
      DEBUG_MODE = 1'b1;
      wr(8'h13, 32'hFFFFFFA5);
      wr(8'h14, 32'hFFFFFFFF);
      rd(8'h13, '1, 32'hA5);
      rd(8'h14, '1, 32'h1F);
      close_out();
   end
endmodule
`default_nettype wire
